// ---- tx_descriptor_handler_tb.sv ----
`timescale 1ns/1ps
`include "txd_defines.svh"
// ====================
// Bench
module tx_descriptor_handler_tb;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic memReq;
  logic memWrite;
  logic [23:0] memAddr;
  logic [15:0] memWdata;
  logic memAck;
  logic [15:0] memRdata;
  logic bufReq;
  logic [23:0] bufAddr;
  logic [11:0] bufLen;
  logic bufLast;
  logic fcsEnable;
  logic bufDone = 1'b0;
  logic [7:0] mac = 8'h00;
  logic transmitterOn;
  logic macAbort;
  int aborts = 0;
  int miscompares = 0;
  int n_checks = 0;
  logic [31:0] rd;
  logic er;
  txd_top i_txd_top (.*, .macStart(mac[0]), .macDefer(mac[1]),
    .macCollision(mac[2]), .macLateCol(mac[3]), .macUnderflow(mac[4]),
    .macCarrier(~mac[5]), .macDone(mac[6]), .linkFail(mac[7]),
    .macAbort(macAbort));
  // Abort pulses last one cycle, so they are counted as they happen
  always @(posedge clk_sys)
    if (macAbort === 1'b1)
      aborts++;
  txd_mem_model i_txd_mem_model (.*);
  initial
    forever #2 clk_sys = ~clk_sys;
  task automatic stop_test;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic hang;
    miscompares++;
    $display("Error %0t wait ran out", $time);
    stop_test();
  endtask
  task automatic chk(input logic [31:0] g, e, input string s);
    n_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("Error %0t %s got %h exp %h", $time, s, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge clk_sys);
      if (pready === 1'b1)
        break;
    end
    if (n >= 100)
      hang();
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // MAC inputs pass a synchroniser, so pulses last three cycles
  task automatic pulse(input int k);
    mac[k] <= 1'b1;
    repeat (3) @(posedge clk_sys);
    mac[k] <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic run_frame(input int d, input logic [23:0] a,
    input logic [11:0] ln, input logic f, lst, input logic [5:0] ev,
    input logic [15:0] e1, input logic [5:0] e3);
    int t;
    for (t = 0; t < 3000 && bufReq !== 1'b1; t++)
      @(posedge clk_sys);
    if (t >= 3000)
      hang();
    chk(32'(bufAddr), 32'(a), "addr");
    chk(32'(bufLen), 32'(ln), "len");
    chk(32'(fcsEnable), 32'(f), "fcs");
    chk(32'(bufLast), 32'(lst), "last");
    bufDone <= 1'b1;
    @(posedge clk_sys);
    bufDone <= 1'b0;
    if (ev[1])
      pulse(1);
    pulse(0);
    for (t = 2; t < 6; t++)
      if (ev[t])
        pulse(t);
    pulse(6);
    for (t = 0; t < 3000 && i_txd_mem_model.mem[d * 4 + 1][15] !== 1'b0; t++)
      @(posedge clk_sys);
    if (t >= 3000)
      hang();
    chk(32'(i_txd_mem_model.mem[d * 4 + 1]), 32'(e1), "w1");
    chk(32'(i_txd_mem_model.mem[d * 4 + 3][15:10]), 32'(e3), "w3");
    chk(32'(i_txd_mem_model.mem[d * 4 + 2]), 32'({4'hf, -ln}), "w2");
    chk(32'(i_txd_mem_model.mem[d * 4]), 32'(a[15:0]), "w0");
  endtask
  task automatic s_regs;
    apb(1'b0, `TXD_REG_STAT, 32'h0);
    chk(rd, 32'h0, "stat reset");
    apb(1'b0, `TXD_REG_RLEN, 32'h0);
    chk(rd, 32'h1, "rlen reset");
    apb(1'b1, `TXD_REG_RLEN, 32'h8);
    apb(1'b0, `TXD_REG_RLEN, 32'h0);
    chk(rd, 32'h8, "rlen");
    apb(1'b0, 12'h01c, 32'h0);
    chk({31'h0, er}, 32'h1, "unmapped err");
    chk(rd, 32'h0, "unmapped data");
    $display("regs done");
  endtask
  task automatic s_frame;
    i_txd_mem_model.put(0, 16'h1111, 16'h8000, 16'hf001);
    i_txd_mem_model.put(1, 16'h1234, 16'ha35a, 16'hfffd);
    apb(1'b1, `TXD_REG_CTRL, 32'h3);
    run_frame(1, 24'h5a1234, 12'd3, 1'b1, 1'b1, 6'h02, 16'h275a, 6'h00);
    chk(32'(i_txd_mem_model.mem[1]), 32'h8000, "skipped");
    $display("frame done");
  endtask
  task automatic s_latecol;
    i_txd_mem_model.lat = 3;
    i_txd_mem_model.put(2, 16'h0200, 16'h8300, 16'hf000);
    mac[7] <= 1'b1;
    run_frame(2, 24'h000200, 12'd0, 1'b0, 1'b1, 6'h08, 16'h4300, 6'h06);
    mac[7] <= 1'b0;
    chk(32'(transmitterOn), 32'h1, "transmitter_on_status kept");
    chk(32'(aborts), 32'h1, "abort latecol");
    $display("latecol done");
  endtask
  task automatic s_underflow_flag;
    i_txd_mem_model.lat = 0;
    i_txd_mem_model.put(3, 16'h0300, 16'h8200, 16'hfff0);
    run_frame(3, 24'h000300, 12'd16, 1'b0, 1'b0, 6'h10, 16'h4200, 6'h30);
    chk(32'(transmitterOn), 32'h0, "transmitter_on_status off");
    chk(32'(aborts), 32'h2, "abort underflow_flag");
    $display("underflow_flag done");
  endtask
  task automatic s_retry;
    i_txd_mem_model.put(4, 16'h0400, 16'h8300, 16'hfffe);
    apb(1'b1, `TXD_REG_MASK, 32'h40);
    apb(1'b1, `TXD_REG_CTRL, 32'hb);
    run_frame(4, 24'h000400, 12'd2, 1'b0, 1'b1, 6'h04, 16'h4300, 6'h01);
    chk(32'(aborts), 32'h3, "abort retry");
    chk(32'(i_txd_mem_model.mem[19][9:0]), 32'h0, "distance");
    $display("retry done");
  endtask
  initial
  begin
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    s_regs();
    s_frame();
    s_latecol();
    s_underflow_flag();
    s_retry();
    stop_test();
  end
endmodule
bind txd_top txd_asserts i_txd_asserts (.*);

// ---- txd_apb.sv ----
`timescale 1ns/1ps
`include "txd_defines.svh"
module txd_apb
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] statIn,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] ctrl,
  output logic [23:0] ringBase,
  output logic [7:0] ringLen,
  output logic [15:0] maskReg,
  output logic startPulse
);
  // Zero wait state slave; unmapped reads give zero and an error
  wire access = psel && penable;
  wire hitCtrl = paddr == `TXD_REG_CTRL;
  wire hitStat = paddr == `TXD_REG_STAT;
  wire hitRing = paddr == `TXD_REG_RING;
  wire hitRlen = paddr == `TXD_REG_RLEN;
  wire hitMask = paddr == `TXD_REG_MASK;
  wire mapped = hitCtrl | hitStat | hitRing | hitRlen | hitMask;
  wire [31:0] rdMux = hitCtrl ? ctrl :
                      hitStat ? statIn :
                      hitRing ? {8'h00, ringBase} :
                      hitRlen ? {24'h000000, ringLen} :
                      hitMask ? {16'h0000, maskReg} : 32'h0;
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      ctrl <= `TXD_CTRL_RESET;
      ringBase <= 24'h000000;
      ringLen <= 8'h01;
      maskReg <= 16'h0000;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      startPulse <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= (psel && !penable && !pwrite) ? rdMux : prdata;
      startPulse <= access && pready && pwrite && hitCtrl && pwdata[0];
      if (access && pready && pwrite)
      begin
        if (hitCtrl)
          ctrl <= {pwdata[31:1], 1'b0};
        if (hitRing)
          ringBase <= pwdata[23:0];
        if (hitRlen)
          ringLen <= (pwdata[7:0] == 8'h00) ? 8'h01 : pwdata[7:0];
        if (hitMask)
          maskReg <= pwdata[15:0];
      end
    end
  end
endmodule

// ---- txd_asserts.sv ----
`timescale 1ns/1ps
// ====================
// Port checks
module txd_asserts
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic memReq,
  input wire logic memWrite,
  input wire logic [23:0] memAddr,
  input wire logic [15:0] memWdata,
  input wire logic memAck,
  input wire logic bufReq,
  input wire logic [23:0] bufAddr,
  input wire logic [11:0] bufLen,
  input wire logic bufDone,
  input wire logic transmitterOn
);
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  logic [15:0] lastW3;
  logic seen3;
  wire wr3 = memReq && memWrite && memAddr[2:0] == 3'h6;
  wire wr1 = memReq && memWrite && memAddr[2:0] == 3'h2;
  // Status word must land before the owner bit goes back
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      seen3 <= 1'b0;
    else if (memAck && wr3)
      seen3 <= 1'b1;
    else if (memAck && wr1)
      seen3 <= 1'b0;
  end
  always_ff @(posedge clk_sys)
  begin
    if (memAck && wr3)
      lastW3 <= memWdata;
  end
  property p_apbAnswer;
    psel && !penable |=> pready;
  endproperty
  a_apbAnswer: assert property (p_apbAnswer)
    else $error("apb answer late");
  property p_apbMap;
    psel && penable && pready && paddr[1:0] == 2'h0
      |-> pslverr == (paddr > 12'h010);
  endproperty
  a_apbMap: assert property (p_apbMap)
    else $error("apb decode wrong");
  property p_memHold;
    memReq && !memAck |=> memReq && $stable(memAddr)
      && $stable(memWrite) && $stable(memWdata);
  endproperty
  a_memHold: assert property (p_memHold)
    else $error("memory request dropped");
  property p_bufHold;
    bufReq && !bufDone |=> bufReq && $stable(bufAddr) && $stable(bufLen);
  endproperty
  a_bufHold: assert property (p_bufHold)
    else $error("buffer request dropped");
  property p_w1Own;
    wr1 |-> !memWdata[15];
  endproperty
  a_w1Own: assert property (p_w1Own)
    else $error("owner bit kept");
  property p_res;
    wr3 |-> !memWdata[13];
  endproperty
  a_res: assert property (p_res)
    else $error("reserved bit set");
  property p_err;
    wr1 |-> memWdata[14] == (lastW3[14] || lastW3[12]
      || lastW3[11] || lastW3[10]);
  endproperty
  a_err: assert property (p_err)
    else $error("error summary wrong");
  property p_order;
    wr1 |-> seen3;
  endproperty
  a_order: assert property (p_order)
    else $error("owner released before status");
  property p_buffUflo;
    wr3 && memWdata[15] |-> memWdata[14];
  endproperty
  a_buffUflo: assert property (p_buffUflo)
    else $error("buffer error without underflow");
  property p_reset;
    disable iff (1'b0)
    !nrst |=> !memReq && !bufReq && !transmitterOn;
  endproperty
  a_reset: assert property (p_reset)
    else $error("outputs active in reset");
endmodule

// ---- txd_defines.svh ----
`ifndef TXD_DEFINES_SVH
`define TXD_DEFINES_SVH
// Descriptor word 1 (status and control)
`define TXD_W1_OWN 15
`define TXD_W1_ERR 14
`define TXD_W1_FCS 13
`define TXD_W1_MORE 12
`define TXD_W1_ONE 11
`define TXD_W1_DEF 10
`define TXD_W1_SOF 9
`define TXD_W1_EOF 8
// Descriptor word 3 (status)
`define TXD_W3_BUFF 15
`define TXD_W3_UNDERFLOW_FLAG 14
`define TXD_W3_RES 13
`define TXD_W3_LATE_COLLISION_FLAG 12
`define TXD_W3_CARRIER_LOSS_FLAG 11
`define TXD_W3_RETRY_FAILURE_FLAG 10
`define TXD_FDC_W 10
// Retry limit and mode bits
`define TXD_RETRY_LIMIT 5'h10
`define TXD_MASK_SUFLO 6
// APB register map
`define TXD_REG_CTRL 12'h000
`define TXD_REG_STAT 12'h004
`define TXD_REG_RING 12'h008
`define TXD_REG_RLEN 12'h00c
`define TXD_REG_MASK 12'h010
`define TXD_CTRL_RESET 32'h0000_0000
// Timing
`define TXD_CLK_HZ 250000000
`define TXD_FDC_HZ 10000000
`define TXD_FDC_DIV (`TXD_CLK_HZ / `TXD_FDC_HZ)
`endif

// ---- txd_fdc.sv ----
`timescale 1ns/1ps
`include "txd_defines.svh"
module txd_fdc
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic start,
  input wire logic stop,
  output logic [`TXD_FDC_W-1:0] count
);
  // 10 MHz enable from divider; count freezes at stop
  logic [7:0] div;
  logic run;
  wire tick = (div == 8'(`TXD_FDC_DIV - 1));
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      div <= 8'h00;
      run <= 1'b0;
      count <= 10'h000;
    end
    else if (start)
    begin
      div <= 8'h00;
      run <= 1'b1;
      count <= 10'h000;
    end
    else
    begin
      if (stop)
        run <= 1'b0;
      div <= tick ? 8'h00 : div + 8'h01;
      if (run && tick && !stop)
        count <= count + 10'h001;
    end
  end
endmodule

// ---- txd_mem_model.sv ----
`timescale 1ns/1ps
// ====================
// Host descriptor memory
module txd_mem_model
(
  input wire logic clk_sys,
  input wire logic memReq,
  input wire logic memWrite,
  input wire logic [23:0] memAddr,
  input wire logic [15:0] memWdata,
  output logic memAck,
  output logic [15:0] memRdata
);
  logic [15:0] mem [0:255] = '{default: 16'h0000};
  int lat = 0;
  int cnt = 0;
  initial
  begin
    memAck = 1'b0;
    memRdata = 16'h0000;
  end
  // Idle data toggles so a stale word never looks valid
  always @(posedge clk_sys)
  begin
    memAck <= 1'b0;
    memRdata <= ~memRdata;
    if (memReq && !memAck && cnt < lat)
      cnt <= cnt + 1;
    else if (memReq && !memAck)
    begin
      cnt <= 0;
      memAck <= 1'b1;
      if (memWrite)
        mem[memAddr[8:1]] <= memWdata;
      else
        memRdata <= mem[memAddr[8:1]];
    end
  end
  // Owner bit goes last; the host keeps off it afterwards
  task automatic put(input int d, input logic [15:0] w0, w1, w2);
    mem[d * 4] = w0;
    mem[d * 4 + 2] = w2;
    mem[d * 4 + 3] = 16'h0000;
    mem[d * 4 + 1] = w1;
  endtask
endmodule

// ---- txd_pkg.sv ----
package txd_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_RD1 = 4'h1,
    ST_RD0 = 4'h2,
    ST_RD2 = 4'h3,
    ST_SEND = 4'h4,
    ST_PEEK = 4'h5,
    ST_WR3 = 4'h6,
    ST_WR1 = 4'h7,
    ST_NEXT = 4'h8
  } txd_state_t;
endpackage

// ---- txd_top.sv ----
`timescale 1ns/1ps
`include "txd_defines.svh"
// Operation
// - Own bit 15 of word 1 hands descriptor to device; device clears after sending.
// - Neither party touches a descriptor after giving up ownership.
// - Error flag is OR of underflow, late collision, carrier loss, retry fail.
// - Per-frame FCS flag forces FCS; else global disable decides; flag untouched.
// - Multiple-retry flag set when more than one retry was needed.
// - Single-retry flag set for exactly one retry; invalid with late collision.
// - Deferred flag set when channel was busy at transmit time.
// - Skip owned descriptors without start flag until own and start found.
// - End flag marks last buffer; start plus end is whole frame; unchanged.
// - Buffer error when no end flag and next not owned, or underflow first.
// - Buffer error or underflow clears transmitter-on unless suppress bit set.
// - Buffer error always comes with underflow; invalid with late collision.
// - Underflow flag set and frame truncated when FIFO runs dry.
// - Reserved status bit of word 3 is always written zero.
// - Late collision after slot time reported and never retried.
// - AUI carrier loss sets flag yet frame still completes.
// - Twisted-pair link fail sets the carrier loss flag.
// - Retry failure after 16 collisions, or after one with retry disabled.
// - 10-bit fault distance counted at 10 MHz until collision or, in AUI mode only, carrier loss.
// - Buffer address is 16 low bits of word 0 and 8 high of word 1.
module txd_top
(
  input wire logic clk_sys,
  input wire logic nrst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Descriptor memory port (16-bit words)
  output logic memReq,
  output logic memWrite,
  output logic [23:0] memAddr,
  output logic [15:0] memWdata,
  input wire logic memAck,
  input wire logic [15:0] memRdata,
  // Buffer fetch towards FIFO
  output logic bufReq,
  output logic [23:0] bufAddr,
  output logic [11:0] bufLen,
  output logic bufLast,
  output logic fcsEnable,
  input wire logic bufDone,
  // MAC status pins
  input wire logic macStart,
  input wire logic macDefer,
  input wire logic macCollision,
  input wire logic macLateCol,
  input wire logic macUnderflow,
  input wire logic macCarrier,
  input wire logic macDone,
  input wire logic linkFail,
  output logic macAbort,
  output logic transmitterOn
);
  logic [31:0] ctrl;
  logic [23:0] ringBase;
  logic [7:0] ringLen;
  logic [15:0] maskReg;
  logic startPulse;
  logic [`TXD_FDC_W-1:0] fdcCount;
  txd_pkg::txd_state_t state;
  logic [15:0] w0;
  logic [15:0] w1;
  logic [15:0] w2;
  logic [7:0] idx;
  logic [4:0] retries;
  logic inFrame, fDef, fUflo, fLcol, fLcar, fRtry, fBuff, fcsFrame;
  logic [2:0] syncA, syncB;
  logic [2:0] syncC, syncD;
  // Control bits: [1]=global FCS disable, [2]=AUI mode, [3]=disable retry
  wire globalFcsOff = ctrl[1];
  wire auiMode = ctrl[2];
  wire noRetry = ctrl[3];
  // MAC pins come from another part of the chip; treated as asynchronous
  wire sDefer = syncA[1];
  wire sCol = syncA[2];
  wire sLate = syncB[0];
  wire sUflo = syncB[1];
  wire sCar = syncB[2];
  wire sDone = syncC[0];
  wire sStart = syncC[1];
  wire sLink = syncC[2];
  wire [23:0] descAddr = ringBase + {13'h0, idx, 3'h0};
  wire [7:0] nextIdx = (idx + 8'h01 == ringLen) ? 8'h00 : idx + 8'h01;
  wire own = memRdata[`TXD_W1_OWN];
  wire sof = memRdata[`TXD_W1_SOF];
  wire eof = w1[`TXD_W1_EOF];
  wire errAny = fUflo | fLcol | fLcar | fRtry;
  wire retryMax = noRetry || (retries == `TXD_RETRY_LIMIT - 5'h01);
  wire shutdown = (fUflo | fBuff) & ~maskReg[`TXD_MASK_SUFLO];
  wire [15:0] word3 = {fBuff, fUflo, 1'b0, fLcol, fLcar, fRtry,
                       fdcCount};
  wire [15:0] word1 = {1'b0, errAny, w1[13], retries > 5'h01,
                       retries == 5'h01 && !fLcol, fDef,
                       w1[9:0]};
  // First stage for the collision, defer, carrier, underflow and late pins
  logic [5:0] syncF;
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      syncA <= 3'h0;
      syncB <= 3'h0;
      syncC <= 3'h0;
      syncD <= 3'h0;
      syncF <= 6'h00;
    end
    else
    begin
      syncF <= {macCollision, macDefer, 1'b0, macCarrier, macUnderflow,
                macLateCol};
      syncA <= syncF[5:3];
      syncB <= syncF[2:0];
      syncD <= {linkFail, macStart, macDone};
      syncC <= syncD;
    end
  end
  txd_apb apb
  (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .statIn({24'h0, state, 3'h0, transmitterOn}),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .ctrl(ctrl),
    .ringBase(ringBase),
    .ringLen(ringLen),
    .maskReg(maskReg),
    .startPulse(startPulse)
  );
  txd_fdc fdc
  (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .start(sStart && state == txd_pkg::ST_SEND && !inFrame),
    .stop(sCol || (!sCar && auiMode)),
    .count(fdcCount)
  );
  // ========================================
  // Descriptor sequencer
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      state <= txd_pkg::ST_IDLE;
      memReq <= 1'b0;
      memWrite <= 1'b0;
      memAddr <= 24'h0;
      memWdata <= 16'h0;
      bufReq <= 1'b0;
      bufAddr <= 24'h0;
      bufLen <= 12'h0;
      bufLast <= 1'b0;
      fcsEnable <= 1'b0;
      macAbort <= 1'b0;
      transmitterOn <= 1'b0;
      w0 <= 16'h0;
      w1 <= 16'h0;
      w2 <= 16'h0;
      idx <= 8'h00;
      retries <= 5'h00;
      inFrame <= 1'b0;
      {fDef, fUflo, fLcol, fLcar, fRtry, fBuff, fcsFrame} <= 7'h00;
    end
    else
    begin
      macAbort <= 1'b0;
      if (startPulse)
        transmitterOn <= 1'b1;
      // MAC events are sticky per descriptor; set only in SEND and PEEK, never in NEXT where the per-buffer clear happens
      if (state == txd_pkg::ST_SEND || state == txd_pkg::ST_PEEK)
      begin
        if (sDefer)
          fDef <= 1'b1;
        if (sLate)
          fLcol <= 1'b1;
        if (sUflo)
          fUflo <= 1'b1;
        if ((auiMode && !sCar) || (!auiMode && sLink))
          fLcar <= 1'b1;
        if (sCol && !sLate)
        begin
          if (retryMax)
            fRtry <= 1'b1;
          if (!retryMax)
            retries <= retries + 5'h01;
        end
      end
      unique case (state)
        txd_pkg::ST_IDLE:
          if (transmitterOn)
          begin
            memReq <= 1'b1;
            memWrite <= 1'b0;
            memAddr <= descAddr + 24'h2;
            state <= txd_pkg::ST_RD1;
          end
        txd_pkg::ST_RD1:
          if (memAck)
          begin
            memReq <= 1'b0;
            w1 <= memRdata;
            if (own && (sof || inFrame))
            begin
              memReq <= 1'b1;
              memAddr <= descAddr;
              state <= txd_pkg::ST_RD0;
            end
            else if (own)
            begin
              idx <= nextIdx;
              state <= txd_pkg::ST_IDLE;
            end
            else
              state <= txd_pkg::ST_IDLE;
          end
        txd_pkg::ST_RD0:
          if (memAck)
          begin
            w0 <= memRdata;
            memAddr <= descAddr + 24'h4;
            state <= txd_pkg::ST_RD2;
          end
        txd_pkg::ST_RD2:
          if (memAck)
          begin
            memReq <= 1'b0;
            w2 <= memRdata;
            bufAddr <= {w1[7:0], w0};
            bufLen <= 12'h000 - memRdata[11:0];
            bufLast <= w1[`TXD_W1_EOF];
            if (!inFrame)
            begin
              fcsFrame <= w1[`TXD_W1_FCS] | ~globalFcsOff;
              retries <= 5'h00;
            end
            fcsEnable <= inFrame ? fcsFrame :
                         (w1[`TXD_W1_FCS] | ~globalFcsOff);
            bufReq <= 1'b1;
            state <= txd_pkg::ST_SEND;
          end
        txd_pkg::ST_SEND:
        begin
          if (bufDone)
            bufReq <= 1'b0;
          if (fRtry || fLcol)
          begin
            macAbort <= 1'b1;
            bufReq <= 1'b0;
            state <= txd_pkg::ST_WR3;
          end
          else if (bufDone && !eof)
          begin
            memReq <= 1'b1;
            memAddr <= {ringBase + {13'h0, nextIdx, 3'h0}} + 24'h2;
            state <= txd_pkg::ST_PEEK;
          end
          else if (fUflo || (eof && sDone))
            state <= txd_pkg::ST_WR3;
        end
        txd_pkg::ST_PEEK:
          if (fUflo && !memAck)
          begin
            fBuff <= 1'b1;
            memReq <= 1'b0;
            state <= txd_pkg::ST_WR3;
          end
          else if (memAck)
          begin
            memReq <= 1'b0;
            if (!own)
            begin
              fBuff <= 1'b1;
              fUflo <= 1'b1;
              macAbort <= 1'b1;
            end
            state <= txd_pkg::ST_WR3;
          end
        txd_pkg::ST_WR3:
          if (!memReq)
          begin
            memReq <= 1'b1;
            memWrite <= 1'b1;
            memAddr <= descAddr + 24'h6;
            memWdata <= word3;
          end
          else if (memAck)
          begin
            memAddr <= descAddr + 24'h2;
            memWdata <= word1;
            state <= txd_pkg::ST_WR1;
          end
        txd_pkg::ST_WR1:
          if (memAck)
          begin
            memReq <= 1'b0;
            memWrite <= 1'b0;
            state <= txd_pkg::ST_NEXT;
          end
        txd_pkg::ST_NEXT:
        begin
          idx <= nextIdx;
          inFrame <= !eof && !errAny && !fBuff;
          if (shutdown)
            transmitterOn <= 1'b0;
          fDef <= 1'b0;
          fUflo <= 1'b0;
          fLcol <= 1'b0;
          fLcar <= 1'b0;
          fRtry <= 1'b0;
          fBuff <= 1'b0;
          state <= txd_pkg::ST_IDLE;
        end
        default:
          state <= txd_pkg::ST_IDLE;
      endcase
    end
  end
endmodule
